// ===== verilog/ctl_pkg.sv
// constants, register map and types shared by the control input handler
package ctl_pkg;

	// clock and debounce timing
	localparam int CLK_PERIOD_NS = 100; // 10 MHz pclk
	localparam int DEBOUNCE_TIME_US = 10000; // least stable time of a contact
	// least time, so round up to whole cycles
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DB_CNT_W = 17; // holds DEBOUNCE_CYCLES

	// control input positions on the input vector
	localparam int IN_W = 13;
	localparam int IN_BACKLIGHT = 0;
	localparam int IN_TOUCH_LOCK = 1;
	localparam int IN_RESTART = 2;
	localparam int IN_RECIPE_LSB = 3; // four bits, weight 1 first
	localparam int IN_ZONE = 7;
	localparam int IN_CLEAR = 8;
	localparam int IN_INHIBIT = 9;
	localparam int IN_RUN = 10;
	localparam int IN_DISP_ZERO = 11;
	localparam int IN_DIGITAL_ZERO = 12;

	// data widths
	localparam int SEL_W = 4;
	localparam int RECIPE_W = 5;
	localparam int ZONE_COUNT = 5;
	localparam int ZONE_W = 3;
	localparam int JUDGE_W = 11;
	localparam int READ_W = 24;
	localparam int ADDR_W = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] REG_CONFIG = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] REG_COMMAND = 12'h008;
	localparam logic [ADDR_W-1:0] REG_DISP_ZERO = 12'h00C;
	localparam logic [ADDR_W-1:0] REG_LOAD_ZERO = 12'h010;

	// configuration fields
	localparam int CFG_RECIPE_EXT = 0; // external_terminal_source for recipes
	localparam int CFG_ZONE_EXT = 1; // external_terminal_source for zones
	localparam int CFG_BEGIN_EXT = 2; // measurement_begin_condition
	localparam int CFG_END_EXT = 3; // measurement_end_condition
	localparam int CFG_RUN_LEVEL = 4; // external_run_control_style, 1 = level
	localparam int CFG_PORT_REAR = 5; // serial on rear connector
	localparam int CFG_ZONE_EN_LSB = 8; // five zone enables
	localparam int CFG_RECIPE_LSB = 16; // software recipe select
	localparam logic [31:0] CONFIG_RESET = 32'h0000_1F20;
	localparam logic [31:0] CONFIG_MASK = 32'h000F_1F3F;

	// status fields
	localparam int ST_BACKLIGHT = 0;
	localparam int ST_TOUCH_LOCK = 1;
	localparam int ST_INHIBIT = 2;
	localparam int ST_MEASURING = 3;
	localparam int ST_DIRTY = 4;
	localparam int ST_RECIPE_LSB = 8;
	localparam int ST_ZONE_LSB = 16;

	// command bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_ZONE_NEXT = 2;
	localparam int CMD_CLEAR = 3;

	// results clear sequence
	typedef enum logic [1:0] {CLR_IDLE, CLR_BLANK, CLR_RESUME} clr_state_t;

endpackage : ctl_pkg

// ===== verilog/ctl_in_if.sv
// carrier between the handler and its input filter
`timescale 1ns/10ps
interface ctl_in_if;
	import ctl_pkg::*;
	logic [IN_W-1:0] raw; // active high, unfiltered
	logic [IN_W-1:0] clean; // synchronised and debounced
	modport source (output raw, input clean);
	modport filter (input raw, output clean);
endinterface : ctl_in_if

// ===== verilog/ctl_debounce.sv
// two-flop synchroniser and debounce filter for each control input
`timescale 1ns/10ps
module ctl_debounce
	import ctl_pkg::*;
#(
	parameter logic [DB_CNT_W-1:0] DEBOUNCE_LEN = DB_CNT_W'(DEBOUNCE_CYCLES)
) (
	input wire logic pclk,
	input wire logic presetn,
	ctl_in_if.filter ins
);

	logic [IN_W-1:0] meta_q; // first stage, read by sync_q only
	logic [IN_W-1:0] sync_q; // second stage
	logic [IN_W-1:0] clean_q; // accepted level
	logic [DB_CNT_W-1:0] cnt_q [IN_W]; // stable time per input

	// synchroniser; isolated contacts arrive with no relation to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= ins.raw;
			sync_q <= meta_q;
		end
	end

	// a new level is taken only after it held for the whole window;
	// bounce restarts the count, so chatter never reaches the handler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clean_q <= '0;
			for (int i = 0; i < IN_W; i++) begin
				cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < IN_W; i++) begin
				if (sync_q[i] == clean_q[i]) begin
					cnt_q[i] <= '0;
				end else if (cnt_q[i] >= DEBOUNCE_LEN - 1'b1) begin
					clean_q[i] <= sync_q[i];
					cnt_q[i] <= '0;
				end else begin
					cnt_q[i] <= cnt_q[i] + 1'b1;
				end
			end
		end
	end

	assign ins.clean = clean_q;

endmodule : ctl_debounce

// ===== verilog/ctl_input_handler.sv
// control input handler with apb register file
//
// Behaviour
// - backlight forced on while input active
// - touch ignored while lock input active
// - restart unit on restart input activation
// - recipe inputs used only when source external
// - recipe equals one plus binary select value
// - zone input acts only when source external
// - zone switching skips zones with judgment disabled
// - clear input discards stored judgment results
// - clear blanks judgment outputs, then resumes continuous
// - inhibit input holds all judgment outputs off
// - run input used when begin/end condition external
// - edge mode toggles run on each activation
// - level mode starts run on activation, stops it on release
// - displacement zero captures present displacement reading
// - digital zero captures present load reading
// - serial uses rear or usb, never both
// - settings committed only on return home
`timescale 1ns/10ps
module ctl_input_handler
	import ctl_pkg::*;
#(
	parameter logic [DB_CNT_W-1:0] DEBOUNCE_LEN = DB_CNT_W'(DEBOUNCE_CYCLES)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic [IN_W-1:0] ctl_in_n,
	input wire logic [READ_W-1:0] load_value,
	input wire logic [READ_W-1:0] disp_value,
	input wire logic [JUDGE_W-1:0] judge_in,
	input wire logic touch_event,
	input wire logic home_return,
	input wire logic serial_tx,
	input wire logic rear_rx,
	input wire logic usb_rx,
	output logic backlight_on_q,
	output logic touch_locked_q,
	output logic touch_pass_q,
	output logic unit_restart_q,
	output logic [RECIPE_W-1:0] recipe_num_q,
	output logic [ZONE_W-1:0] zone_num_q,
	output logic [JUDGE_W-1:0] judge_out_q,
	output logic results_clear_q,
	output logic continue_start_q,
	output logic measuring_q,
	output logic [READ_W-1:0] disp_zero_q,
	output logic [READ_W-1:0] load_zero_q,
	output logic nvm_commit_q,
	output logic rear_tx_q,
	output logic usb_tx_q,
	output logic serial_rx_q
);

	// recipe number from a four bit select, 1 to 16
	function automatic logic [RECIPE_W-1:0] recipe_of(input logic [SEL_W-1:0] sel);
		return {1'b0, sel} + 5'h01;
	endfunction : recipe_of

	// next enabled zone after cur, wrapping; stays put if none enabled
	function automatic logic [ZONE_W-1:0] next_zone(
		input logic [ZONE_W-1:0] cur,
		input logic [ZONE_COUNT-1:0] en
	);
		logic [ZONE_W-1:0] z;
		logic [ZONE_W-1:0] pick;
		logic found;
		z = cur;
		pick = cur;
		found = 1'b0;
		for (int i = 0; i < ZONE_COUNT; i++) begin
			z = (z == ZONE_W'(ZONE_COUNT - 1)) ? '0 : z + 1'b1;
			if (!found && en[z]) begin
				pick = z;
				found = 1'b1;
			end
		end
		return pick;
	endfunction : next_zone

	ctl_in_if ins (); // raw pins to filter and back

	logic [IN_W-1:0] prev_q; // clean levels one cycle ago
	logic [IN_W-1:0] rise; // inactive to active, one cycle
	logic [IN_W-1:0] fall; // active to inactive, one cycle
	logic [31:0] cfg_q; // configuration register
	logic dirty_q; // settings changed since last commit
	clr_state_t clr_q; // results clear sequence
	logic [31:0] rd_data; // read mux
	logic rd_ok; // address is mapped
	logic setup; // apb setup phase
	logic done; // apb access completes this edge
	logic wr; // accepted write
	logic cfg_wr; // write to configuration
	logic [3:0] cmd; // command pulses
	logic ext_run; // run input owns measurement
	logic clear_go; // start a results clear
	logic [ZONE_COUNT-1:0] zone_en; // zones with judgment enabled
	logic rear_sel; // serial routed to rear connector

	// a shorted contact pulls the pin low, so low means on
	assign ins.raw = ~ctl_in_n;

	ctl_debounce #(
		.DEBOUNCE_LEN(DEBOUNCE_LEN)
	) u_debounce (
		.pclk(pclk),
		.presetn(presetn),
		.ins(ins)
	);

	// transitions of the filtered inputs
	assign rise = ins.clean & ~prev_q;
	assign fall = ~ins.clean & prev_q;

	// configuration views
	assign zone_en = cfg_q[CFG_ZONE_EN_LSB +: ZONE_COUNT];
	assign rear_sel = cfg_q[CFG_PORT_REAR];
	assign ext_run = cfg_q[CFG_BEGIN_EXT] | cfg_q[CFG_END_EXT];

	// apb phases; one wait-free access phase after each setup
	assign setup = psel & ~penable;
	assign done = psel & penable & pready_q;
	assign wr = done & pwrite & ~pslverr_q;
	assign cfg_wr = wr && (paddr == REG_CONFIG);
	assign cmd = (wr && (paddr == REG_COMMAND)) ? pwdata[3:0] : 4'h0;

	// a clear from the pin or from software
	assign clear_go = rise[IN_CLEAR] | cmd[CMD_CLEAR];

	// edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= ins.clean;
		end
	end

	// read decode; status shows the block's live state
	always_comb begin
		rd_data = '0;
		rd_ok = 1'b1;
		unique case (paddr)
			REG_CONFIG: rd_data = cfg_q;
			REG_STATUS: begin
				rd_data[ST_BACKLIGHT] = backlight_on_q;
				rd_data[ST_TOUCH_LOCK] = touch_locked_q;
				rd_data[ST_INHIBIT] = ins.clean[IN_INHIBIT];
				rd_data[ST_MEASURING] = measuring_q;
				rd_data[ST_DIRTY] = dirty_q;
				rd_data[ST_RECIPE_LSB +: RECIPE_W] = recipe_num_q;
				rd_data[ST_ZONE_LSB +: ZONE_W] = zone_num_q;
			end
			REG_COMMAND: rd_data = '0; // write only, reads zero
			REG_DISP_ZERO: rd_data = {8'h00, disp_zero_q};
			REG_LOAD_ZERO: rd_data = {8'h00, load_zero_q};
			default: rd_ok = 1'b0; // unmapped
		endcase
	end

	// apb answer: ready, data and error are set up at the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			prdata_q <= (setup && !pwrite) ? rd_data : '0;
			pslverr_q <= setup & ~rd_ok;
		end
	end

	// configuration register; unused bits stay zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= CONFIG_RESET;
		end else if (cfg_wr) begin
			cfg_q <= pwdata & CONFIG_MASK;
		end
	end

	// pending settings; a change in the commit cycle keeps the flag set
	// so that it is not lost with the commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dirty_q <= 1'b0;
			nvm_commit_q <= 1'b0;
		end else begin
			nvm_commit_q <= home_return & dirty_q;
			if (cfg_wr) begin
				dirty_q <= 1'b1;
			end else if (home_return) begin
				dirty_q <= 1'b0;
			end
		end
	end

	// panel levels follow their inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			backlight_on_q <= 1'b0;
			touch_locked_q <= 1'b0;
			touch_pass_q <= 1'b0;
		end else begin
			backlight_on_q <= ins.clean[IN_BACKLIGHT];
			touch_locked_q <= ins.clean[IN_TOUCH_LOCK];
			touch_pass_q <= touch_event & ~ins.clean[IN_TOUCH_LOCK];
		end
	end

	// restart is a one-cycle pulse; a held input restarts only once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_restart_q <= 1'b0;
		end else begin
			unit_restart_q <= rise[IN_RESTART];
		end
	end

	// recipe select; software choice applies when not external
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recipe_num_q <= 5'h01;
		end else if (cfg_q[CFG_RECIPE_EXT]) begin
			recipe_num_q <= recipe_of(ins.clean[IN_RECIPE_LSB +: SEL_W]);
		end else begin
			recipe_num_q <= recipe_of(cfg_q[CFG_RECIPE_LSB +: SEL_W]);
		end
	end

	// zone switching, pin when external, command otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zone_num_q <= '0;
		end else if (cfg_q[CFG_ZONE_EXT]) begin
			if (rise[IN_ZONE]) begin
				zone_num_q <= next_zone(zone_num_q, zone_en);
			end
		end else if (cmd[CMD_ZONE_NEXT]) begin
			zone_num_q <= next_zone(zone_num_q, zone_en);
		end
	end

	// clear sequence: blank outputs, then resume continuous judgment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_q <= CLR_IDLE;
		end else begin
			unique case (clr_q)
				CLR_IDLE: begin
					if (clear_go) begin
						clr_q <= CLR_BLANK;
					end
				end
				// a second clear while blanking keeps the outputs dark one more cycle
				CLR_BLANK: clr_q <= clear_go ? CLR_BLANK : CLR_RESUME;
				CLR_RESUME: clr_q <= clear_go ? CLR_BLANK : CLR_IDLE;
			endcase
		end
	end

	// judgment outputs; inhibit and clear both force them off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			judge_out_q <= '0;
			results_clear_q <= 1'b0;
			continue_start_q <= 1'b0;
		end else begin
			results_clear_q <= clear_go;
			continue_start_q <= (clr_q == CLR_BLANK);
			if (ins.clean[IN_INHIBIT] || clear_go || clr_q == CLR_BLANK) begin
				judge_out_q <= '0;
			end else begin
				judge_out_q <= judge_in;
			end
		end
	end

	// measurement run state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			measuring_q <= 1'b0;
		end else if (ext_run) begin
			if (cfg_q[CFG_RUN_LEVEL]) begin
				if (rise[IN_RUN]) begin
					measuring_q <= 1'b1;
				end else if (fall[IN_RUN]) begin
					measuring_q <= 1'b0;
				end
			end else if (rise[IN_RUN]) begin
				measuring_q <= ~measuring_q;
			end
		end else if (cmd[CMD_START]) begin
			measuring_q <= 1'b1;
		end else if (cmd[CMD_STOP]) begin
			measuring_q <= 1'b0;
		end
	end

	// zero captures on activation only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_zero_q <= '0;
			load_zero_q <= '0;
		end else begin
			if (rise[IN_DISP_ZERO]) begin
				disp_zero_q <= disp_value;
			end
			if (rise[IN_DIGITAL_ZERO]) begin
				load_zero_q <= load_value;
			end
		end
	end

	// serial routing; the idle port is held at line idle, so two ports
	// can never talk at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rear_tx_q <= 1'b1;
			usb_tx_q <= 1'b1;
			serial_rx_q <= 1'b1;
		end else begin
			rear_tx_q <= rear_sel ? serial_tx : 1'b1;
			usb_tx_q <= rear_sel ? 1'b1 : serial_tx;
			serial_rx_q <= rear_sel ? rear_rx : usb_rx;
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_BACKLIGHT: assert property (ins.clean[IN_BACKLIGHT] |=> backlight_on_q)
		else $error("backlight not forced on");
	AST_TOUCH: assert property (!(touch_locked_q && touch_pass_q))
		else $error("touch passed while locked");
	AST_RESTART: assert property (rise[IN_RESTART] |=> unit_restart_q ##1 !unit_restart_q)
		else $error("restart pulse wrong");
	// the flop takes the pins one edge late, so compare against the past select
	AST_RECIPE: assert property (cfg_q[CFG_RECIPE_EXT]
		|=> recipe_num_q == {1'b0, $past(ins.clean[IN_RECIPE_LSB +: SEL_W])} + 5'h01)
		else $error("recipe number wrong");
	AST_ZONE_HOLD: assert property (!cfg_q[CFG_ZONE_EXT] && !cmd[CMD_ZONE_NEXT]
		|=> $stable(zone_num_q))
		else $error("zone moved without request");
	AST_ZONE_EN: assert property ($changed(zone_num_q) && $stable(cfg_q)
		|-> zone_en[zone_num_q])
		else $error("switched to disabled zone");
	AST_CLEAR: assert property (clear_go |=> results_clear_q && judge_out_q == '0
		##1 continue_start_q && judge_out_q == '0)
		else $error("clear sequence wrong");
	AST_INHIBIT: assert property (ins.clean[IN_INHIBIT] |=> judge_out_q == '0)
		else $error("judgment out while inhibited");
	AST_EDGE: assert property (ext_run && !cfg_q[CFG_RUN_LEVEL] && rise[IN_RUN]
		|=> measuring_q != $past(measuring_q))
		else $error("edge mode did not toggle");
	AST_LEVEL: assert property (ext_run && cfg_q[CFG_RUN_LEVEL] && fall[IN_RUN]
		|=> !measuring_q)
		else $error("level mode did not stop");
	AST_ZERO: assert property (rise[IN_DISP_ZERO] |=> disp_zero_q == $past(disp_value))
		else $error("displacement zero not captured");
	AST_DZ: assert property (rise[IN_DIGITAL_ZERO] |=> load_zero_q == $past(load_value))
		else $error("digital zero not captured");
	AST_PORT: assert property (!(rear_tx_q == 1'b0 && usb_tx_q == 1'b0))
		else $error("both serial ports active");
	AST_COMMIT: assert property (nvm_commit_q |-> $past(home_return) && $past(dirty_q))
		else $error("commit without home return");

endmodule : ctl_input_handler

// ===== bench/ctl_contacts.sv
// switch contact model standing on the control connector
`timescale 1ns/10ps
module ctl_contacts
	import ctl_pkg::*;
(
	input wire logic pclk,
	input wire logic [IN_W-1:0] closed, // contacts shorted to common
	input wire logic bounce, // chatter back for one cycle after each change
	output logic [IN_W-1:0] ctl_in_n // pin levels seen by the block
);
	logic [IN_W-1:0] prev_q; // contact state one cycle ago
	logic [IN_W-1:0] chg_q; // contacts that changed last cycle

	// remember the last state so a change can chatter once
	always_ff @(posedge pclk) begin
		prev_q <= closed;
		chg_q <= closed ^ prev_q;
	end

	// shorted reads low, open floats to the pull-up, real contacts bounce
	assign ctl_in_n = ~closed ^ (bounce ? chg_q : '0);
endmodule : ctl_contacts

// ===== bench/tb_top.sv
// self-checking bench for the control input handler
`timescale 1ns/10ps
module tb_top;
	import ctl_pkg::*;
	localparam logic [DB_CNT_W-1:0] DB = 17'h00004; // short debounce keeps the run brief
	localparam int SETTLE = 12; // sync, debounce, chatter and output flop with margin
	logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, err, bounce;
	logic touch_event, home_return, serial_tx, rear_rx, usb_rx;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata_q, rd;
	logic [IN_W-1:0] ctl_in_n, closed;
	logic [READ_W-1:0] load_value, disp_value, disp_zero_q, load_zero_q;
	logic [JUDGE_W-1:0] judge_in, judge_out_q;
	logic backlight_on_q, touch_locked_q, touch_pass_q, unit_restart_q, results_clear_q;
	logic continue_start_q, measuring_q, nvm_commit_q, rear_tx_q, usb_tx_q, serial_rx_q;
	logic [RECIPE_W-1:0] recipe_num_q;
	logic [ZONE_W-1:0] zone_num_q;
	int err_total, n_tests, n_restart, n_clear, n_cont, n_commit;
	logic [ZONE_W-1:0] zone_exp [3] = '{3'h2, 3'h4, 3'h0}; // zones 1 and 3 disabled

	ctl_input_handler #(.DEBOUNCE_LEN(DB)) i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .ctl_in_n, .load_value,
		.disp_value, .judge_in, .touch_event, .home_return, .serial_tx, .rear_rx, .usb_rx,
		.backlight_on_q, .touch_locked_q, .touch_pass_q, .unit_restart_q, .recipe_num_q,
		.zone_num_q, .judge_out_q, .results_clear_q, .continue_start_q, .measuring_q,
		.disp_zero_q, .load_zero_q, .nvm_commit_q, .rear_tx_q, .usb_tx_q, .serial_rx_q);
	ctl_contacts i_contacts (.pclk, .closed, .bounce, .ctl_in_n);

	// free running 10 MHz clock
	always #50 pclk = ~pclk;

	// compare one value and count it
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// print the counts and the verdict, then stop
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop

	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready_q === 1'b1) break;
		end
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			err_total++;
			report_and_stop();
		end
	endtask : apb

	// close or open one contact, then let the filter settle
	task pin(input int idx, input logic on);
		@(posedge pclk);
		closed[idx] <= on;
		repeat (SETTLE) @(posedge pclk);
	endtask : pin

	// one pulse from the operator returning home
	task home;
		@(posedge pclk);
		home_return <= 1'b1;
		@(posedge pclk);
		home_return <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : home

	// count one-shot pulses and check blanking during a clear
	always @(posedge pclk) begin
		if (unit_restart_q === 1'b1) n_restart++;
		if (continue_start_q === 1'b1) n_cont++;
		if (nvm_commit_q === 1'b1) n_commit++;
		if (results_clear_q === 1'b1) begin
			n_clear++;
			chk("judge blank", 32'h0, judge_out_q);
		end
	end

	// hang guard
	initial begin
		repeat (50000) @(posedge pclk);
		err_total++;
		report_and_stop();
	end

	// main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, home_return, rear_rx, usb_rx} = '0;
		{touch_event, serial_tx, bounce} = 3'h7;
		paddr = '0;
		pwdata = '0;
		closed = '0;
		load_value = 24'h000000;
		disp_value = 24'h000000;
		judge_in = 11'h5A5;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, REG_CONFIG, 0);
		chk("config reset", CONFIG_RESET, rd);
		apb(0, 12'h0FC, 0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		home();
		chk("no commit clean", 0, n_commit);
		$display("test reset done");
		pin(IN_BACKLIGHT, 1);
		chk("backlight", 1, backlight_on_q);
		apb(1, REG_STATUS, 32'hFFFF_FFFF);
		apb(0, REG_STATUS, 0);
		chk("status", 32'h0000_0101, rd);
		pin(IN_BACKLIGHT, 0);
		chk("backlight off", 0, backlight_on_q);
		chk("touch pass", 1, touch_pass_q);
		pin(IN_TOUCH_LOCK, 1);
		chk("touch locked", 0, touch_pass_q);
		chk("touch lock level", 1, touch_locked_q);
		pin(IN_TOUCH_LOCK, 0);
		chk("touch free", 1, touch_pass_q);
		pin(IN_RESTART, 1);
		pin(IN_RESTART, 0);
		chk("restart once", 1, n_restart);
		$display("test levels done");
		apb(1, REG_CONFIG, CONFIG_RESET | 32'h0007_0000);
		@(posedge pclk);
		closed[IN_RECIPE_LSB +: SEL_W] <= 4'hA;
		repeat (SETTLE) @(posedge pclk);
		chk("recipe internal", 8, recipe_num_q);
		apb(1, REG_CONFIG, CONFIG_RESET | (32'h1 << CFG_RECIPE_EXT));
		for (int v = 0; v < 16; v++) begin
			@(posedge pclk);
			closed[IN_RECIPE_LSB +: SEL_W] <= v[3:0];
			repeat (SETTLE) @(posedge pclk);
			chk("recipe pins", v + 1, recipe_num_q);
		end
		$display("test recipe done");
		pin(IN_ZONE, 1);
		pin(IN_ZONE, 0);
		chk("zone internal", 0, zone_num_q);
		apb(1, REG_CONFIG, 32'h0000_1522);
		for (int k = 0; k < 3; k++) begin
			pin(IN_ZONE, 1);
			pin(IN_ZONE, 0);
			chk("zone next", zone_exp[k], zone_num_q);
		end
		$display("test zone done");
		chk("judge pass", 11'h5A5, judge_out_q);
		pin(IN_CLEAR, 1);
		chk("clear once", 1, n_clear);
		chk("continue", 1, n_cont);
		chk("judge resumed", 11'h5A5, judge_out_q);
		pin(IN_CLEAR, 0);
		pin(IN_INHIBIT, 1);
		chk("inhibit", 0, judge_out_q);
		pin(IN_INHIBIT, 0);
		chk("inhibit off", 11'h5A5, judge_out_q);
		$display("test judgment done");
		apb(1, REG_CONFIG, CONFIG_RESET);
		pin(IN_RUN, 1);
		pin(IN_RUN, 0);
		chk("run internal", 0, measuring_q);
		apb(1, REG_CONFIG, CONFIG_RESET | (32'h1 << CFG_BEGIN_EXT));
		pin(IN_RUN, 1);
		chk("edge start", 1, measuring_q);
		pin(IN_RUN, 0);
		chk("edge hold", 1, measuring_q);
		pin(IN_RUN, 1);
		chk("edge stop", 0, measuring_q);
		pin(IN_RUN, 0);
		apb(1, REG_CONFIG, CONFIG_RESET | 32'h0000_0018);
		pin(IN_RUN, 1);
		chk("level start", 1, measuring_q);
		pin(IN_RUN, 0);
		chk("level stop", 0, measuring_q);
		// software commands while every source is internal
		apb(1, REG_CONFIG, CONFIG_RESET);
		apb(1, REG_COMMAND, 32'h0000_0001);
		@(posedge pclk);
		chk("cmd start", 1, measuring_q);
		apb(1, REG_COMMAND, 32'h0000_0002);
		@(posedge pclk);
		chk("cmd stop", 0, measuring_q);
		apb(1, REG_COMMAND, 32'h0000_0004);
		@(posedge pclk);
		chk("cmd zone", 1, zone_num_q);
		apb(1, REG_COMMAND, 32'h0000_0008);
		repeat (3) @(posedge pclk);
		chk("cmd clear", 2, n_clear);
		chk("cmd continue", 2, n_cont);
		$display("test run done");
		disp_value <= 24'h123456;
		load_value <= 24'hABCDEF;
		pin(IN_DISP_ZERO, 1);
		pin(IN_DIGITAL_ZERO, 1);
		disp_value <= 24'h000111;
		load_value <= 24'h000222;
		repeat (4) @(posedge pclk);
		chk("disp zero", 24'h123456, disp_zero_q);
		chk("load zero", 24'hABCDEF, load_zero_q);
		apb(0, REG_DISP_ZERO, 0);
		chk("disp zero reg", 32'h0012_3456, rd);
		apb(0, REG_LOAD_ZERO, 0);
		chk("load zero reg", 32'h00AB_CDEF, rd);
		$display("test zero done");
		serial_tx <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("rear tx", 0, rear_tx_q);
		chk("usb idle", 1, usb_tx_q);
		chk("rear rx", 0, serial_rx_q);
		apb(1, REG_CONFIG, CONFIG_RESET & ~(32'h1 << CFG_PORT_REAR));
		usb_rx <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("usb tx", 0, usb_tx_q);
		chk("rear idle", 1, rear_tx_q);
		chk("usb rx", 1, serial_rx_q);
		$display("test serial done");
		home();
		chk("commit", 1, n_commit);
		home();
		chk("commit once", 1, n_commit);
		$display("test commit done");
		report_and_stop();
	end
endmodule : tb_top
